// file: logic/pcap_pkg.sv
// Package for the power budget, access control and latency report register bank.
// Assumes an APB slave at 32-bit data, one aligned word per register.
package pcap_pkg;

    // Register byte offsets
    localparam logic [11:0] PCAP_OFF_PWR_DATA  = 12'h214;
    localparam logic [11:0] PCAP_OFF_PWR_CAP   = 12'h218;
    localparam logic [11:0] PCAP_OFF_ACS_HDR   = 12'h220;
    localparam logic [11:0] PCAP_OFF_ACS_CTRL  = 12'h224;
    localparam logic [11:0] PCAP_OFF_EGRESS    = 12'h228;
    localparam logic [11:0] PCAP_OFF_LTR_HDR   = 12'h230;
    // Own register holding the power data index
    localparam logic [11:0] PCAP_OFF_DATA_SEL  = 12'h210;

    // Power data defaults
    localparam logic [7:0]  PCAP_RST_BASE_PWR  = 8'h04;
    localparam logic [1:0]  PCAP_RST_SCALE     = 2'h0;
    localparam logic [2:0]  PCAP_RST_SUBSTATE  = 3'h0;
    localparam logic [1:0]  PCAP_RST_PM_STATE  = 2'h0;
    localparam logic [2:0]  PCAP_TYPE_MAX      = 3'h7;
    localparam logic [2:0]  PCAP_TYPE_SUST     = 3'h3;
    localparam logic [2:0]  PCAP_RST_RAIL      = 3'h2;
    localparam logic        PCAP_RST_SYS_ALLOC = 1'b0;
    localparam logic [7:0]  PCAP_SEL_D0_MAX    = 8'h00;
    localparam logic [7:0]  PCAP_SEL_D0_SUST   = 8'h01;

    // Capability headers
    localparam logic [15:0] PCAP_ACS_ID        = 16'h000d;
    localparam logic [15:0] PCAP_LTR_ID        = 16'h0018;
    localparam logic [3:0]  PCAP_CAP_VER       = 4'h1;
    localparam logic [11:0] PCAP_NEXT_PTR      = 12'h240;

    // Access control capability fields
    localparam logic [6:0]  PCAP_ACS_SUPPORT   = 7'h7f;
    localparam logic [7:0]  PCAP_EGRESS_SIZE   = 8'h08;
    localparam int          PCAP_ACS_EN_LSB    = 16;
    localparam logic [6:0]  PCAP_RST_ACS_EN    = 7'h00;
    localparam logic [7:0]  PCAP_RST_EGRESS    = 8'h00;
    localparam logic [7:0]  PCAP_RST_DATA_SEL  = 8'h00;

    // Power data defaults loaded from the management bus or EEPROM
    typedef struct packed {
        logic [7:0] base_pwr;
        logic [1:0] scale;
        logic [1:0] pm_state;
        logic       sys_alloc;
    } pcap_load_s;

    // APB request
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } pcap_apb_req_s;

    // APB answer
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pcap_apb_rsp_s;

endpackage

// file: logic/pcap_default_hold.sv
// Holder for the loadable read-only power defaults.
// Assumes load strobes synchronous to sys_clk.
`timescale 1ns/1ns
module pcap_default_hold (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic                 load_valid,
    input  wire pcap_pkg::pcap_load_s load_value,
    output pcap_pkg::pcap_load_s      held
);

    typedef struct packed {
        pcap_pkg::pcap_load_s val;
    } pcap_hold_state_s;

    pcap_hold_state_s state_r;
    pcap_hold_state_s state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        if (load_valid) begin
            state_nxt.val = load_value;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_r.val.base_pwr  <= pcap_pkg::PCAP_RST_BASE_PWR;
            state_r.val.scale     <= pcap_pkg::PCAP_RST_SCALE;
            state_r.val.pm_state  <= pcap_pkg::PCAP_RST_PM_STATE;
            state_r.val.sys_alloc <= pcap_pkg::PCAP_RST_SYS_ALLOC;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign held = state_r.val;

endmodule

// file: logic/pcap_regs.sv
// Register bank: power budget data, access control services, latency report header.
// Assumes an APB master on sys_clk and a port-role strap stable while out of reset.
`timescale 1ns/1ns

// What this block does
// - Base power byte, read-only, reset 04h
// - Data scale bits 9:8, reset 00b
// - PM sub state bits 12:10, reset 000b
// - PM state bits 14:13, default D0
// - Condition type bits 17:15, default maximum
// - Power rail bits 20:18, reset 010b
// - System allocated flag bit 0, reset 0
// - Power defaults replaceable by external load
// - Downstream ACS header ID 000Dh version 1
// - Next pointer 240h in both headers
// - Upstream LTR header ID 0018h version 1
// - Seven Access_control_cap_ctrl bits read one
// - Egress vector size reads 08h
// - Seven read-write ACS enables, reset zero
// - Egress control vector 8 bits, reset zero
// - Power data follows select index
module pcap_regs (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire logic                    is_upstream,
    input  wire pcap_pkg::pcap_apb_req_s apb_req,
    output pcap_pkg::pcap_apb_rsp_s      apb_rsp,
    input  wire logic                    load_valid,
    input  wire pcap_pkg::pcap_load_s    load_value,
    output logic [6:0]                   acs_enable,
    output logic [7:0]                   egress_block
);

    typedef struct packed {
        logic [6:0]  acs_en;
        logic [7:0]  egress;
        logic [7:0]  data_sel;
        logic [31:0] rdata;
        logic        slverr;
    } pcap_state_s;

    pcap_state_s          state_r;
    pcap_state_s          state_nxt;
    pcap_pkg::pcap_load_s dflt;
    logic                 access;
    logic                 wr_lane0;
    logic                 wr_lane2;
    logic [31:0]          pwr_word;
    logic [31:0]          rd_word;
    logic                 rd_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Loadable defaults
    pcap_default_hold u_hold (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .load_valid (load_valid),
        .load_value (load_value),
        .held       (dflt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign access   = apb_req.psel && apb_req.penable;
    assign wr_lane0 = access && apb_req.pwrite && apb_req.pstrb[0];
    assign wr_lane2 = access && apb_req.pwrite && apb_req.pstrb[2];

    ////////////////////////////////////////////////////////////////////////////
    // Power data word
    always_comb begin
        pwr_word = 32'h0000_0000;
        if (state_r.data_sel == pcap_pkg::PCAP_SEL_D0_MAX ||
            state_r.data_sel == pcap_pkg::PCAP_SEL_D0_SUST) begin
            pwr_word[7:0]   = dflt.base_pwr;
            pwr_word[9:8]   = dflt.scale;
            pwr_word[12:10] = pcap_pkg::PCAP_RST_SUBSTATE;
            pwr_word[14:13] = dflt.pm_state;
            pwr_word[17:15] = (state_r.data_sel == pcap_pkg::PCAP_SEL_D0_MAX) ?
                              pcap_pkg::PCAP_TYPE_MAX : pcap_pkg::PCAP_TYPE_SUST;
            pwr_word[20:18] = pcap_pkg::PCAP_RST_RAIL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (apb_req.paddr)
            pcap_pkg::PCAP_OFF_DATA_SEL: begin
                rd_word[7:0] = state_r.data_sel;
            end
            pcap_pkg::PCAP_OFF_PWR_DATA: begin
                rd_word = pwr_word;
            end
            pcap_pkg::PCAP_OFF_PWR_CAP: begin
                rd_word[0] = dflt.sys_alloc;
            end
            pcap_pkg::PCAP_OFF_ACS_HDR: begin
                rd_hit = !is_upstream;
                if (!is_upstream) begin
                    rd_word = {pcap_pkg::PCAP_NEXT_PTR, pcap_pkg::PCAP_CAP_VER, pcap_pkg::PCAP_ACS_ID};
                end
            end
            pcap_pkg::PCAP_OFF_ACS_CTRL: begin
                rd_hit = !is_upstream;
                if (!is_upstream) begin
                    rd_word[6:0]  = pcap_pkg::PCAP_ACS_SUPPORT;
                    rd_word[15:8] = pcap_pkg::PCAP_EGRESS_SIZE;
                    rd_word[22:16] = state_r.acs_en;
                end
            end
            pcap_pkg::PCAP_OFF_EGRESS: begin
                rd_hit = !is_upstream;
                if (!is_upstream) begin
                    rd_word[7:0] = state_r.egress;
                end
            end
            pcap_pkg::PCAP_OFF_LTR_HDR: begin
                rd_hit = is_upstream;
                if (is_upstream) begin
                    rd_word = {pcap_pkg::PCAP_NEXT_PTR, pcap_pkg::PCAP_CAP_VER, pcap_pkg::PCAP_LTR_ID};
                end
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_nxt = state_r;
        // Answer captured in the setup cycle, shown during the access cycle
        if (apb_req.psel && !apb_req.penable) begin
            state_nxt.slverr = !rd_hit;
            state_nxt.rdata  = apb_req.pwrite ? 32'h0000_0000 : rd_word;
        end
        if (wr_lane0 && apb_req.paddr == pcap_pkg::PCAP_OFF_DATA_SEL) begin
            state_nxt.data_sel = apb_req.pwdata[7:0];
        end
        if (wr_lane2 && !is_upstream && apb_req.paddr == pcap_pkg::PCAP_OFF_ACS_CTRL) begin
            state_nxt.acs_en = apb_req.pwdata[22:16];
        end
        if (wr_lane0 && !is_upstream && apb_req.paddr == pcap_pkg::PCAP_OFF_EGRESS) begin
            state_nxt.egress = apb_req.pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_r.acs_en   <= pcap_pkg::PCAP_RST_ACS_EN;
            state_r.egress   <= pcap_pkg::PCAP_RST_EGRESS;
            state_r.data_sel <= pcap_pkg::PCAP_RST_DATA_SEL;
            state_r.rdata    <= 32'h0000_0000;
            state_r.slverr   <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        apb_rsp.pready  = apb_req.psel && apb_req.penable;
        apb_rsp.pslverr = apb_rsp.pready && state_r.slverr;
        apb_rsp.prdata  = apb_rsp.pready ? state_r.rdata : 32'h0000_0000;
    end

    assign acs_enable   = state_r.acs_en;
    assign egress_block = state_r.egress;

endmodule

// file: testbench/pcap_regs_monitor.sv
// Checker for the power budget, access control and latency report register bank.
// Assumes it is bound to pcap_regs and sees only that module's ports.
`timescale 1ns/1ns
module pcap_regs_monitor (
    input wire logic                    sys_clk,
    input wire logic                    resetn,
    input wire logic                    is_upstream,
    input wire pcap_pkg::pcap_apb_req_s apb_req,
    input wire pcap_pkg::pcap_apb_rsp_s apb_rsp,
    input wire logic                    load_valid,
    input wire pcap_pkg::pcap_load_s    load_value,
    input wire logic [6:0]              acs_enable,
    input wire logic [7:0]              egress_block
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire acc = apb_req.psel && apb_req.penable;
    ////////////////////////////////////////////////////////////////
    sequence s_wr(logic [11:0] a);
        acc && apb_req.pwrite && apb_req.paddr == a && !is_upstream;
    endsequence
    sequence s_rd(logic [11:0] a);
        acc && !apb_req.pwrite && apb_req.paddr == a;
    endsequence
    property p_egr_wr;
        s_wr(12'h228) ##0 apb_req.pstrb[0] |=> egress_block == $past(apb_req.pwdata[7:0]);
    endproperty
    property p_acs_wr;
        s_wr(12'h224) ##0 apb_req.pstrb[2] |=> acs_enable == $past(apb_req.pwdata[22:16]);
    endproperty
    property p_keep;
        !(acc && apb_req.pwrite) |=> $stable(acs_enable) && $stable(egress_block);
    endproperty
    property p_rst;
        @(posedge sys_clk) disable iff (1'b0) !resetn |=> acs_enable == 7'h00 && egress_block == 8'h00;
    endproperty
    property p_acs_hdr;
        s_rd(12'h220) ##0 !is_upstream |-> apb_rsp.prdata == 32'h2401000d;
    endproperty
    property p_ltr_hdr;
        s_rd(12'h230) ##0 is_upstream |-> apb_rsp.prdata == 32'h24010018;
    endproperty
    property p_cap;
        s_rd(12'h224) ##0 !is_upstream |-> apb_rsp.prdata == {9'h000, acs_enable, 16'h087f};
    endproperty
    property p_data;
        s_rd(12'h214) |-> apb_rsp.prdata == 32'h0 || apb_rsp.prdata[31:18] == 14'h0002 && apb_rsp.prdata[12:10] == 3'h0;
    endproperty
    property p_load;
        load_valid ##3 s_rd(12'h218) |-> apb_rsp.prdata == {31'h0, $past(load_value.sys_alloc, 3)};
    endproperty
    a_egr_wr: assert property (p_egr_wr) else $error("egress vector not written");
    a_acs_wr: assert property (p_acs_wr) else $error("acs enables not written");
    a_keep: assert property (p_keep) else $error("enables changed without write");
    a_rst: assert property (p_rst) else $error("enables not cleared by reset");
    a_acs_hdr: assert property (p_acs_hdr) else $error("acs header wrong");
    a_ltr_hdr: assert property (p_ltr_hdr) else $error("ltr header wrong");
    a_cap: assert property (p_cap) else $error("access_control_cap_ctrl word wrong");
    a_data: assert property (p_data) else $error("power data fields wrong");
    a_load: assert property (p_load) else $error("loaded flag not visible");
endmodule
bind pcap_regs pcap_regs_monitor pcap_regs_monitor_inst (.sys_clk(sys_clk), .resetn(resetn),
    .is_upstream(is_upstream), .apb_req(apb_req), .apb_rsp(apb_rsp), .load_valid(load_valid),
    .load_value(load_value), .acs_enable(acs_enable), .egress_block(egress_block));

// file: testbench/pcie_ext_cap_power_acs_ltr_tb_top.sv
// Testbench for the power budget, access control and latency report register bank.
// Assumes the APB slave answers through pready; the bench drives all ports.
`timescale 1ns/1ns
module pcie_ext_cap_power_acs_ltr_tb_top;
    logic                    sys_clk, resetn, is_upstream, load_valid, err;
    pcap_pkg::pcap_apb_req_s req;
    pcap_pkg::pcap_apb_rsp_s rsp;
    pcap_pkg::pcap_load_s    ld;
    logic [6:0]              acs_en;
    logic [7:0]              egr;
    logic [31:0]             rd;
    int                      mismatches, total_checks;
    logic [11:0]             adr [5] = '{12'h214, 12'h218, 12'h220, 12'h224, 12'h228};
    logic [31:0]             dflt [5] = '{32'h000b8004, 32'h0, 32'h2401000d, 32'h0000087f, 32'h0};
    logic [31:0]             full [5] = '{32'h000b8004, 32'h0, 32'h2401000d, 32'h007f087f, 32'h000000ff};
    pcap_regs pcap_regs_inst (.sys_clk(sys_clk), .resetn(resetn), .is_upstream(is_upstream), .apb_req(req),
        .apb_rsp(rsp), .load_valid(load_valid), .load_value(ld), .acs_enable(acs_en), .egress_block(egr));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, d, s};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do @(posedge sys_clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0, 4'hf);
        chk(rd, e);
    endtask
    task automatic rst(input logic up);
        @(posedge sys_clk);
        resetn <= 1'b0;
        is_upstream <= up;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge sys_clk);
        mismatches++;
        summarize();
    end
    initial begin
        resetn = 1'b0;
        is_upstream = 1'b0;
        load_valid = 1'b0;
        req = '0;
        ld = '0;
        rst(1'b0);
        for (int i = 0; i < 5; i++) begin
            rc(adr[i], dflt[i]);
            apb(adr[i], 1'b1, 32'hffffffff, 4'hf);
            rc(adr[i], full[i]);
        end
        rc(12'h230, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({25'h0, acs_en}, 32'h7f);
        chk({24'h0, egr}, 32'hff);
        apb(12'h228, 1'b1, 32'h0, 4'he);
        rc(12'h228, 32'hff);
        apb(12'h224, 1'b1, 32'h00550000, 4'hf);
        @(posedge sys_clk);
        chk({25'h0, acs_en}, 32'h55);
        apb(12'h210, 1'b1, 32'h1, 4'hf);
        rc(12'h214, 32'h00098004);
        apb(12'h210, 1'b1, 32'hff, 4'hf);
        rc(12'h214, 32'h0);
        apb(12'h210, 1'b1, 32'h0, 4'hf);
        @(posedge sys_clk);
        ld <= '{8'h5a, 2'h2, 2'h3, 1'b1};
        load_valid <= 1'b1;
        @(posedge sys_clk);
        load_valid <= 1'b0;
        rc(12'h218, 32'h1);
        rc(12'h214, 32'h000be25a);
        rst(1'b1);
        chk({25'h0, acs_en}, 32'h0);
        apb(12'h228, 1'b1, 32'hff, 4'hf);
        @(posedge sys_clk);
        chk({24'h0, egr}, 32'h0);
        rc(12'h230, 32'h24010018);
        rc(12'h220, 32'h0);
        chk({31'h0, err}, 32'h1);
        rc(12'h214, 32'h000b8004);
        summarize();
    end
endmodule
